/* File: inc/qdist_defines.svh */
// constants for the quiescence channel distributor
`ifndef QDIST_DEFINES_SVH
`define QDIST_DEFINES_SVH

// ==========================================================
// channel count bounds
`define QD_CH_MIN 2
`define QD_CH_MAX 32

// ==========================================================
// reset values
`define QD_REQ_N_RST 1'b1
`define QD_ACC_N_RST 1'b1
`define QD_DENY_RST 1'b0
`define QD_ACT_RST 1'b0

// ==========================================================
// input synchroniser depth in flip-flops
`define QD_SYNC_DEPTH 3

`endif

/* File: inc/qdist_pkg.sv */
// types for the quiescence channel distributor
package qdist_pkg;

  // ==========================================================
  // sequencing states, one-hot
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_ENTRY = 5'h02,
    ST_STOPPED = 5'h04,
    ST_DENIED = 5'h08,
    ST_EXIT = 5'h10
  } seq_state_t;

  // ==========================================================
  // response driven back to the controller
  typedef struct packed {
    logic accept_n;
    logic deny;
  } ctrl_resp_t;

endpackage

/* File: verilog/quiesce_channel_distributor.sv */
// fans one upstream quiescence handshake out to several downstream channels
`timescale 1ns/100ps
`default_nettype none
`include "qdist_defines.svh"

module quiesce_channel_distributor
  import qdist_pkg::*;
#(
  parameter int channel_count = 2,
  parameter bit sequencer_en = 1'b0,
  parameter bit upstream_input_sync_en = 1'b1,
  parameter bit downstream_input_sync_en = 1'b1,
  parameter bit activity_denial_en = 1'b1,
  parameter bit activity_sync_en = 1'b0
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic ctrl_req_n_in,
  output logic ctrl_accept_n_out,
  output logic ctrl_deny_out,
  output logic ctrl_active_out,
  output logic clk_active_out,
  output logic [channel_count-1:0] dev_req_n_out,
  input wire logic [channel_count-1:0] dev_accept_n_in,
  input wire logic [channel_count-1:0] dev_deny_in,
  input wire logic [channel_count-1:0] dev_active_in
);

  // ==========================================================
  // configuration checks
  localparam int N = channel_count;
  localparam int IW = $clog2(N);
  localparam int W = 3 * N + 1;
  localparam logic [IW-1:0] LAST = IW'(N - 1);

  if (N < `QD_CH_MIN || N > `QD_CH_MAX) begin : g_bad_count
    $error("channel_count out of range");
  end

  // ==========================================================
  // input synchronisers
  // bit 0 upstream request, then accepts, denies, activities
  logic [W-1:0] raw;
  logic [W-1:0] syn;
  logic req_int;
  logic [N-1:0] acc_int;
  logic [N-1:0] deny_int;
  logic [N-1:0] act_int;

  assign raw = {dev_active_in, dev_deny_in, dev_accept_n_in, ctrl_req_n_in};

  genvar g;
  for (g = 0; g < W; g++) begin : g_sync
    localparam bit RV = (g <= N);
    localparam bit EN = (g == 0) ? upstream_input_sync_en :
                        (g <= 2 * N) ? downstream_input_sync_en : activity_sync_en;
    if (EN) begin : g_on
      logic [`QD_SYNC_DEPTH-1:0] sh;
      logic filt;
      // settled value moves only when the last two stages agree
      always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          sh <= {`QD_SYNC_DEPTH{RV}};
          filt <= RV;
        end else begin
          sh <= {sh[`QD_SYNC_DEPTH-2:0], raw[g]};
          if (sh[`QD_SYNC_DEPTH-2] == sh[`QD_SYNC_DEPTH-1]) begin
            filt <= sh[`QD_SYNC_DEPTH-1];
          end
        end
      end
      assign syn[g] = filt;
    end else begin : g_off
      assign syn[g] = raw[g];
    end
  end

  assign req_int = syn[0];
  assign acc_int = syn[N:1];
  assign deny_int = syn[2*N:N+1];
  assign act_int = syn[3*N:2*N+1];

  // ==========================================================
  // combinational outputs
  // activity bypasses any synchroniser so the controller sees it at once
  assign ctrl_active_out = |dev_active_in;

  // raw pins used here so the clock is asked for before sync settles
  assign clk_active_out = |(dev_req_n_out ^ dev_accept_n_in) | (|dev_deny_in)
                        | (ctrl_req_n_in ^ ctrl_accept_n_out) | ctrl_deny_out;

  // ==========================================================
  // sequencing state
  seq_state_t state;
  seq_state_t next_state;
  logic [IW-1:0] idx;
  logic [IW-1:0] next_idx;
  logic [N-1:0] dev_req_n;
  logic [N-1:0] next_req_n;
  ctrl_resp_t resp;
  ctrl_resp_t next_resp;
  logic act_hit;
  logic next_hit;
  logic act_trip;
  logic all_running;
  logic cur_running;

  assign act_trip = activity_denial_en & (|act_int);
  assign all_running = (&dev_req_n) & (&acc_int) & ~(|deny_int);
  assign cur_running = dev_req_n[idx] & acc_int[idx] & ~deny_int[idx];

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_req_n = dev_req_n;
    next_resp = resp;
    next_hit = act_hit;
    unique case (state)
      ST_RUN: begin
        if (!req_int) begin
          next_state = ST_ENTRY;
          next_hit = 1'b0;
          if (sequencer_en) begin
            next_idx = LAST;
            next_req_n[LAST] = 1'b0;
          end else begin
            next_req_n = '0;
          end
        end
      end
      ST_ENTRY: begin
        if (sequencer_en) begin
          // remembered so a trip between responses is not lost
          if (act_trip) begin
            next_hit = 1'b1;
          end
          if (deny_int[idx]) begin
            next_resp.deny = 1'b1;
            next_state = ST_DENIED;
          end else if (!acc_int[idx]) begin
            if (act_hit || act_trip) begin
              next_resp.deny = 1'b1;
              next_state = ST_DENIED;
            end else if (idx == '0) begin
              next_resp.accept_n = 1'b0;
              next_state = ST_STOPPED;
            end else begin
              next_idx = idx - IW'(1);
              next_req_n[idx - IW'(1)] = 1'b0;
            end
          end
        end else begin
          if (~(|acc_int)) begin
            next_resp.accept_n = 1'b0;
            next_state = ST_STOPPED;
          end else if ((|deny_int) || act_trip) begin
            next_resp.deny = 1'b1;
            next_req_n = '1;
            next_state = ST_DENIED;
          end
        end
      end
      ST_DENIED: begin
        if (sequencer_en) begin
          // walk upward from the channel where entry stopped
          next_req_n[idx] = 1'b1;
          if (cur_running && idx != LAST) begin
            next_idx = idx + IW'(1);
          end
        end
        if (all_running && req_int) begin
          next_resp.deny = 1'b0;
          next_state = ST_RUN;
        end
      end
      ST_STOPPED: begin
        if (req_int) begin
          next_state = ST_EXIT;
          if (sequencer_en) begin
            next_idx = '0;
            next_req_n[0] = 1'b1;
          end else begin
            next_req_n = '1;
          end
        end
      end
      ST_EXIT: begin
        if (sequencer_en) begin
          if (acc_int[idx]) begin
            if (idx == LAST) begin
              next_resp.accept_n = 1'b1;
              next_state = ST_RUN;
            end else begin
              next_idx = idx + IW'(1);
              next_req_n[idx + IW'(1)] = 1'b1;
            end
          end
        end else if (&acc_int) begin
          next_resp.accept_n = 1'b1;
          next_state = ST_RUN;
        end
      end
      default: begin
        // illegal one-hot code: fall back to running, answer idle
        next_state = ST_RUN;
        next_req_n = '1;
        next_resp = '{accept_n: `QD_ACC_N_RST, deny: `QD_DENY_RST};
      end
    endcase
  end

  // ==========================================================
  // registers, one block per concern
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idx <= '0;
    end else begin
      idx <= next_idx;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dev_req_n <= {N{`QD_REQ_N_RST}};
    end else begin
      dev_req_n <= next_req_n;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      resp.accept_n <= `QD_ACC_N_RST;
      resp.deny <= `QD_DENY_RST;
    end else begin
      resp <= next_resp;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      act_hit <= `QD_ACT_RST;
    end else begin
      act_hit <= next_hit;
    end
  end

  assign dev_req_n_out = dev_req_n;
  assign ctrl_accept_n_out = resp.accept_n;
  assign ctrl_deny_out = resp.deny;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  a_accept_all_low: assert property (
    $fell(ctrl_accept_n_out) |-> $past(~(|acc_int))
  ) else $error("accept low before every device accepted");

  a_accept_all_high: assert property (
    $rose(ctrl_accept_n_out) |-> $past(&acc_int) && (&dev_req_n_out)
  ) else $error("accept high before every device exited");

  a_deny_release: assert property (
    $fell(ctrl_deny_out) |-> $past(all_running) && $past(req_int)
  ) else $error("deny dropped too early");

  a_deny_cause: assert property (
    $rose(ctrl_deny_out) |-> $past(|deny_int) || $past(act_trip) || $past(act_hit)
  ) else $error("deny raised without cause");

  a_clk_on_deny: assert property (
    ctrl_deny_out || (dev_req_n_out != dev_accept_n_in) |-> clk_active_out
  ) else $error("clock request missing");

  a_bcast_issue: assert property (
    !sequencer_en && state == ST_RUN && !req_int |=> dev_req_n_out == '0
  ) else $error("broadcast request not sent to all");

  a_seq_top_first: assert property (
    sequencer_en && state == ST_RUN && !req_int
    |=> dev_req_n_out == ~(N'(1) << LAST)
  ) else $error("sequential entry did not start at top channel");

  a_seq_exit_zero: assert property (
    sequencer_en && state == ST_STOPPED && req_int
    |=> dev_req_n_out[0] && idx == '0 ##1 state == ST_EXIT
  ) else $error("sequential exit did not start at channel zero");

  a_denied_held: assert property (
    state == ST_DENIED && !all_running |=> ctrl_deny_out
  ) else $error("deny lost while restoring");

  a_active_or: assert property (
    ctrl_active_out == (|dev_active_in)
  ) else $error("upstream activity differs from device activity");

  a_clk_upstream: assert property (
    (ctrl_req_n_in != ctrl_accept_n_out) || (|dev_deny_in) |-> clk_active_out
  ) else $error("clock request missing during upstream handshake");

  a_no_entry_denied: assert property (
    state == ST_DENIED |=> &(~$past(dev_req_n_out) | dev_req_n_out)
  ) else $error("entry request sent while denying");

  c_accept: cover property ($fell(ctrl_accept_n_out));
  c_act_denial: cover property (act_hit && state == ST_DENIED);
  c_denial: cover property ($rose(ctrl_deny_out) ##[1:200] $fell(ctrl_deny_out));
  c_exit: cover property (state == ST_EXIT ##1 state == ST_RUN);

endmodule

`default_nettype wire

/* File: sim/qdev_model.sv */
// downstream quiescence devices with programmable reply delay and deny
`timescale 1ns/100ps
`default_nettype none
module qdev_model #(parameter int n = 4) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [n-1:0] req_n_in,
  input wire logic [n-1:0] deny_mask_in,
  input wire logic [2:0] delay_in,
  output logic [n-1:0] accept_n_out,
  output logic [n-1:0] deny_out
);
  // ==========================================================
  // one four-phase device per channel
  for (genvar i = 0; i < n; i++) begin : g_ch
    logic acc_n;
    logic dny;
    logic [2:0] cnt;
    // pending: request differs from accept, or a deny awaits its withdrawal
    wire logic busy = (!dny && (req_n_in[i] != acc_n)) || (dny && req_n_in[i]);
    always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        acc_n <= 1'b1;
        dny <= 1'b0;
        cnt <= 3'h0;
      end else if (!busy) begin
        cnt <= 3'h0;
      end else if (cnt < delay_in) begin
        cnt <= cnt + 3'h1;
      end else begin
        cnt <= 3'h0;
        if (req_n_in[i]) begin
          acc_n <= 1'b1;
          dny <= 1'b0;
        end else if (deny_mask_in[i]) begin
          dny <= 1'b1;
        end else begin
          acc_n <= 1'b0;
        end
      end
    end
    assign accept_n_out[i] = acc_n;
    assign deny_out[i] = dny;
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the distributor in sequencing and broadcast modes
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import qdist_pkg::*;
  localparam int n = 4;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ctrl_req_n_in = 1'b1;
  logic ctrl_accept_n_out, ctrl_deny_out, ctrl_active_out, clk_active_out;
  logic [n-1:0] dev_req_n_out, dev_accept_n_in, dev_deny_in;
  logic bc_accept_n, bc_deny, bc_active, bc_clk;
  logic [n-1:0] bc_req_n, bc_acc_n, bc_deny_dev;
  logic [n-1:0] dev_active_in = '0;
  logic [n-1:0] deny_mask = '0;
  logic [n-1:0] prev_req = '1;
  logic [2:0] delay = 3'h0;
  int fails = 0;
  int cmp_count = 0;
  int seed = 10342;
  int ev_q[$];
  int exp_q[$];
  always #12.5 clock_in = ~clock_in;
  quiesce_channel_distributor #(.channel_count(n), .sequencer_en(1'b1)) u_dut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .ctrl_req_n_in(ctrl_req_n_in),
    .ctrl_accept_n_out(ctrl_accept_n_out), .ctrl_deny_out(ctrl_deny_out),
    .ctrl_active_out(ctrl_active_out), .clk_active_out(clk_active_out),
    .dev_req_n_out(dev_req_n_out), .dev_accept_n_in(dev_accept_n_in),
    .dev_deny_in(dev_deny_in), .dev_active_in(dev_active_in));
  qdev_model #(.n(n)) u_devs (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .req_n_in(dev_req_n_out), .deny_mask_in(deny_mask), .delay_in(delay),
    .accept_n_out(dev_accept_n_in), .deny_out(dev_deny_in));
  // broadcast twin shares the controller request and the activity inputs
  quiesce_channel_distributor #(.channel_count(n), .sequencer_en(1'b0)) u_dut_bcast (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .ctrl_req_n_in(ctrl_req_n_in),
    .ctrl_accept_n_out(bc_accept_n), .ctrl_deny_out(bc_deny),
    .ctrl_active_out(bc_active), .clk_active_out(bc_clk),
    .dev_req_n_out(bc_req_n), .dev_accept_n_in(bc_acc_n),
    .dev_deny_in(bc_deny_dev), .dev_active_in(dev_active_in));
  qdev_model #(.n(n)) u_bc_devs (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .req_n_in(bc_req_n), .deny_mask_in(deny_mask), .delay_in(delay),
    .accept_n_out(bc_acc_n), .deny_out(bc_deny_dev));
  // ==========================================================
  // reporting and bounded waits
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wait_out(input bit sel_deny, input logic v);
    for (int k = 0; k < 3000; k++) begin
      @(negedge clock_in);
      if (sel_deny && ctrl_deny_out === v && bc_deny === v) return;
      if (!sel_deny && ctrl_accept_n_out === v && bc_accept_n === v) return;
    end
    fails++;
    $display("ERROR wait expected %b seen %b %b", v, ctrl_deny_out, ctrl_accept_n_out);
    end_of_test();
  endtask
  task automatic cmp_order();
    bit bad;
    bad = (ev_q.size() != exp_q.size());
    for (int i = 0; i < exp_q.size(); i++) begin
      if (!bad && ev_q[i] != exp_q[i]) begin
        bad = 1'b1;
      end
    end
    cmp_count++;
    if (bad) begin
      fails++;
      $display("ERROR order expected %p seen %p", exp_q, ev_q);
    end
  endtask
  // ==========================================================
  // combinational outputs and request order, every cycle
  always @(negedge clock_in) begin
    if (rst_b_in) begin
      check1("ctrl_active", |dev_active_in, ctrl_active_out);
      check1("clk_active", |(dev_req_n_out ^ dev_accept_n_in) | |dev_deny_in |
        (ctrl_req_n_in ^ ctrl_accept_n_out) | ctrl_deny_out, clk_active_out);
      check1("bc ctrl_active", |dev_active_in, bc_active);
      check1("bc clk_active", |(bc_req_n ^ bc_acc_n) | (|bc_deny_dev) |
        (ctrl_req_n_in ^ bc_accept_n) | bc_deny, bc_clk);
      check1("bc req_n", 1'b1, (&bc_req_n) | (~(|bc_req_n)));
      for (int i = 0; i < n; i++) begin
        if (dev_req_n_out[i] !== prev_req[i]) ev_q.push_back(2 * i + dev_req_n_out[i]);
      end
      prev_req = dev_req_n_out;
    end
  end
  // dch below zero: every channel accepts; otherwise channel dch denies
  task automatic run(input int dch);
    int lo;
    lo = (dch < 0) ? 0 : dch;
    ev_q.delete();
    exp_q.delete();
    for (int c = n - 1; c >= lo; c--) exp_q.push_back(2 * c);
    @(posedge clock_in);
    delay <= 3'($random(seed) & 3);
    deny_mask <= (dch < 0) ? '0 : n'(1 << dch);
    ctrl_req_n_in <= 1'b0;
    if (dch < 0) begin
      wait_out(1'b0, 1'b0);
      check1("deny", 1'b0, ctrl_deny_out);
      check1("bc deny", 1'b0, bc_deny);
      for (int c = 0; c < n; c++) exp_q.push_back(2 * c + 1);
      @(posedge clock_in);
      ctrl_req_n_in <= 1'b1;
      wait_out(1'b0, 1'b1);
    end else begin
      wait_out(1'b1, 1'b1);
      check1("accept", 1'b1, ctrl_accept_n_out);
      check1("bc accept", 1'b1, bc_accept_n);
      for (int c = dch; c < n; c++) exp_q.push_back(2 * c + 1);
      @(posedge clock_in);
      ctrl_req_n_in <= 1'b1;
      wait_out(1'b1, 1'b0);
      check1("req_n", 1'b1, &dev_req_n_out);
      check1("bc req_n", 1'b1, &bc_req_n);
    end
    cmp_order();
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(negedge clock_in);
    check1("accept", 1'b1, ctrl_accept_n_out);
    check1("req_n", 1'b1, &dev_req_n_out);
    run(-1);
    for (int k = 0; k < n; k++) run(k);
    run(-1);
    // activity raised mid-entry must deny and unwind every channel
    ev_q.delete();
    exp_q.delete();
    @(posedge clock_in);
    deny_mask <= '0;
    delay <= 3'h3;
    ctrl_req_n_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    dev_active_in <= n'(1 << ($random(seed) & 3));
    wait_out(1'b1, 1'b1);
    @(posedge clock_in);
    dev_active_in <= '0;
    repeat (60) @(negedge clock_in);
    check1("deny", 1'b1, ctrl_deny_out);
    check1("bc deny", 1'b1, bc_deny);
    @(posedge clock_in);
    ctrl_req_n_in <= 1'b1;
    wait_out(1'b1, 1'b0);
    check1("req_n", 1'b1, &dev_req_n_out);
    check1("accept", 1'b1, ctrl_accept_n_out);
    check1("bc req_n", 1'b1, &bc_req_n);
    // top channel was being asked when activity rose: it stops, then is restored
    exp_q.push_back(2 * (n - 1));
    exp_q.push_back(2 * n - 1);
    cmp_order();
    end_of_test();
  end
endmodule
`default_nettype wire
